// >>> bench/bir_board_regs_tb.sv
`include "bir_defs.svh"

module bir_board_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset, enable, acquisition
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic acq_done = 1'b0;
  // bus requests
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // bus answers
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // board information, steady
  logic [15:0] prod_year = 16'h07e2;
  logic [7:0] prod_month = 8'h05, interrupt_line_used = 8'h0b;
  logic [31:0] board_serial = 32'h0001_2345, max_sample_rate = 32'h0beb_c200, installed_memory_bytes = 32'h0400_0000;
  // options packed, bit 0 multi record up to bit 7 amp calibration
  logic [7:0] opt = 8'h00;
  logic opt_multi_record, opt_digital_inputs, opt_gated_sampling, opt_synchronization;
  logic opt_time_tagging, opt_sync_hub_module, opt_extra_io, opt_amp_calibration;
  assign {opt_amp_calibration, opt_extra_io, opt_sync_hub_module, opt_time_tagging, opt_synchronization,
    opt_gated_sampling, opt_digital_inputs, opt_multi_record} = opt;
  // control outputs
  logic low_power, run_active, mem_valid, board_reset;
  logic reset_seen = 1'b0; // sticky, the pulse lasts one cycle only
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  // expected option words; hub also sets sync, amp dropped on digitizers
  logic [31:0] opt_exp [8] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0020, 32'h0000_0200,
    32'h0000_0400, 32'h0000_0a00, 32'h0000_2000, 32'h0000_0000};

  bir_board_regs u_bir_board_regs (
    .ref_clk(ref_clk), .srst(srst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .prod_year(prod_year), .prod_month(prod_month), .board_serial(board_serial),
    .max_sample_rate(max_sample_rate), .installed_memory_bytes(installed_memory_bytes),
    .interrupt_line_used(interrupt_line_used),
    .opt_multi_record(opt_multi_record), .opt_digital_inputs(opt_digital_inputs),
    .opt_gated_sampling(opt_gated_sampling), .opt_synchronization(opt_synchronization),
    .opt_time_tagging(opt_time_tagging), .opt_sync_hub_module(opt_sync_hub_module),
    .opt_extra_io(opt_extra_io), .opt_amp_calibration(opt_amp_calibration),
    .acq_done(acq_done),
    .low_power(low_power), .run_active(run_active), .mem_valid(mem_valid), .board_reset(board_reset)
  );

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (board_reset === 1'b1) reset_seen <= 1'b1;

  // byte address of a register index
  function automatic logic [15:0] ba(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // address and data offered together, each dropped once taken
  // waits for the answer however long; only the watchdog ends a hang
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask : wr

  task automatic rdr(input logic [15:0] a);
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    #1;
  endtask : rdr

  // one acquisition done pulse, then let it land
  task automatic pulse_done();
    @(posedge ref_clk) acq_done <= 1'b1;
    @(posedge ref_clk) acq_done <= 1'b0;
    @(posedge ref_clk) #1;
  endtask : pulse_done

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // hang guard, far beyond the hundred or so cycles the tests need
  initial
  begin
    #100000;
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rdr(ba(`BIR_IDX_DATE)); check("date", rd, {prod_year, 8'h00, prod_month});
    rdr(ba(`BIR_IDX_SERIAL)); check("serial", rd, board_serial);
    rdr(ba(`BIR_IDX_RATE)); check("rate", rd, max_sample_rate);
    rdr(ba(`BIR_IDX_MEMSIZE)); check("memsize", rd, installed_memory_bytes);
    rdr(ba(`BIR_IDX_IRQ)); check("irq", rd, {24'h00_0000, interrupt_line_used});
    rdr(ba(`BIR_IDX_CAPACITY)); check("capacity", rd, 32'h0200_0000);
    rdr(ba(`BIR_IDX_STATUS)); check("bytes per sample", rd[5:4], 32'h0000_0002);
    $display("test info done");
    for (int i = 0; i < 8; i++)
    begin
      opt <= 8'h01 << i;
      rdr(ba(`BIR_IDX_OPTIONS)); check("options", rd, opt_exp[i]);
    end
    opt <= 8'hff;
    rdr(ba(`BIR_IDX_OPTIONS)); check("all options", rd, 32'h0000_2e23);
    $display("test options done");
    // writes to information registers and an unmapped place
    wr(ba(`BIR_IDX_DATE), 32'hffff_ffff); check("date write", rsp, `BIR_RESP_OKAY);
    rdr(ba(`BIR_IDX_DATE)); check("date kept", rd, {prod_year, 8'h00, prod_month});
    wr(ba(`BIR_IDX_SERIAL), 32'h0000_0000); check("serial write", rsp, `BIR_RESP_OKAY);
    // run code at an unaligned alias of the command word must do nothing
    wr(16'h0001, `BIR_CMD_RUN_STANDARD);
    check("unaligned write", {rsp, run_active}, {`BIR_RESP_SLVERR, 1'b0});
    rdr(ba(`BIR_IDX_SERIAL)); check("serial kept", rd, board_serial);
    rdr(16'h0100); check("unmapped", {rd[29:0], rsp}, {30'h0000_0000, `BIR_RESP_SLVERR});
    $display("test write protect done");
    // start, powerdown, restart, reset from run and from powerdown
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_RUN_STANDARD); check("run", {low_power, run_active}, 2'b01);
    pulse_done(); check("mem after run", mem_valid, 1'b1);
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_LOW_POWER);
    check("powerdown", {low_power, run_active, mem_valid}, 3'b100);
    rdr(ba(`BIR_IDX_COMMAND)); check("command", rd, `BIR_CMD_LOW_POWER);
    pulse_done(); check("mem in powerdown", mem_valid, 1'b0);
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_RUN_STANDARD); check("restart", {low_power, run_active}, 2'b01);
    pulse_done(); check("mem after restart", mem_valid, 1'b1);
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_FULL_RESET);
    check("reset", {low_power, run_active, mem_valid, reset_seen}, 4'b0001);
    rdr(ba(`BIR_IDX_COMMAND)); check("command reset", rd, `BIR_COMMAND_RESET);
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_LOW_POWER); check("down again", low_power, 1'b1);
    wr(ba(`BIR_IDX_COMMAND), `BIR_CMD_FULL_RESET);
    check("wake by reset", {low_power, run_active}, 2'b00);
    $display("test commands done");
    give_verdict();
  end
endmodule : bir_board_regs_tb

bind bir_board_regs bir_regs_props #(.IS_GENERATOR(IS_GENERATOR)) u_bir_regs_props (
  .ref_clk(ref_clk), .srst(srst), .ce(ce),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .prod_year(prod_year), .prod_month(prod_month), .interrupt_line_used(interrupt_line_used),
  .opt_multi_record(opt_multi_record), .opt_digital_inputs(opt_digital_inputs),
  .opt_gated_sampling(opt_gated_sampling), .opt_synchronization(opt_synchronization),
  .opt_time_tagging(opt_time_tagging), .opt_sync_hub_module(opt_sync_hub_module),
  .opt_extra_io(opt_extra_io), .opt_amp_calibration(opt_amp_calibration),
  .low_power(low_power), .run_active(run_active), .mem_valid(mem_valid), .board_reset(board_reset)
);

// >>> bench/bir_regs_props.sv
`include "bir_defs.svh"

module bir_regs_props #(
  parameter bit IS_GENERATOR = 1'b0 // board is a waveform generator
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // read channel
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // board information
  input wire logic [15:0] prod_year,
  input wire logic [7:0] prod_month,
  input wire logic [7:0] interrupt_line_used,
  // fitted options
  input wire logic opt_multi_record,
  input wire logic opt_digital_inputs,
  input wire logic opt_gated_sampling,
  input wire logic opt_synchronization,
  input wire logic opt_time_tagging,
  input wire logic opt_sync_hub_module,
  input wire logic opt_extra_io,
  input wire logic opt_amp_calibration,
  // board control
  input wire logic low_power,
  input wire logic run_active,
  input wire logic mem_valid,
  input wire logic board_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // address of the read in flight, so data can be tied to its register
  logic [15:0] ar_q_r;
  logic new_rd;
  always_ff @(posedge ref_clk)
    ar_q_r <= srst ? 16'h0000 : (s_axi_arvalid && s_axi_arready && ce) ? s_axi_araddr : ar_q_r;
  always_comb new_rd = s_axi_rvalid && (ar_q_r == {2'b00, `BIR_IDX_OPTIONS, 2'b00});
  a_date_layout: assert property ($rose(s_axi_rvalid) && ar_q_r == {2'b00, `BIR_IDX_DATE, 2'b00}
    |-> s_axi_rdata == {prod_year, 8'h00, prod_month}) else $error("date word layout wrong");
  a_irq_line: assert property ($rose(s_axi_rvalid) && ar_q_r == {2'b00, `BIR_IDX_IRQ, 2'b00}
    |-> s_axi_rdata == {24'h00_0000, interrupt_line_used}) else $error("irq line wrong");
  a_opt_low_bits: assert property ($rose(new_rd) |-> s_axi_rdata[5] == opt_gated_sampling
    && s_axi_rdata[1:0] == {opt_digital_inputs, opt_multi_record}) else $error("low option bits");
  a_opt_high_bits: assert property ($rose(new_rd) |-> s_axi_rdata[10] == opt_time_tagging
    && s_axi_rdata[13] == opt_extra_io) else $error("high option bits");
  a_hub_sets_sync: assert property ($rose(new_rd) |-> s_axi_rdata[11] == opt_sync_hub_module
    && s_axi_rdata[9] == (opt_synchronization || opt_sync_hub_module)) else $error("hub bit");
  a_amp_generator_only: assert property ($rose(new_rd)
    |-> s_axi_rdata[14] == (IS_GENERATOR && opt_amp_calibration)) else $error("amp bit");
  a_mode_exclusive: assert property (!(low_power && run_active)) else $error("both modes");
  a_reset_clears_mode: assert property (board_reset |-> !low_power && !run_active)
    else $error("reset left a mode");
  a_reset_single: assert property (board_reset |=> !board_reset) else $error("reset pulse long");
  a_mem_needs_run: assert property ($rose(mem_valid) |-> $past(run_active))
    else $error("memory valid without run");
  // main scenarios reached
  c_low_power: cover property ($rose(low_power));
  c_reset: cover property (board_reset);
  c_mem: cover property ($rose(mem_valid));
endmodule : bir_regs_props

// >>> logic/bir_board_regs.sv
`include "bir_defs.svh"

module bir_board_regs #(
  parameter int SAMPLE_BITS = 12,   // converter resolution
  parameter bit IS_GENERATOR = 1'b0 // board is a waveform generator
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // board information, held steady by the board
  input wire logic [15:0] prod_year,
  input wire logic [7:0] prod_month,
  input wire logic [31:0] board_serial,
  input wire logic [31:0] max_sample_rate,
  input wire logic [31:0] installed_memory_bytes,
  input wire logic [7:0] interrupt_line_used,
  // fitted options
  input wire logic opt_multi_record,
  input wire logic opt_digital_inputs,
  input wire logic opt_gated_sampling,
  input wire logic opt_synchronization,
  input wire logic opt_time_tagging,
  input wire logic opt_sync_hub_module,
  input wire logic opt_extra_io,
  input wire logic opt_amp_calibration,
  // acquisition side
  input wire logic acq_done,
  // board control outputs
  output logic low_power,
  output logic run_active,
  output logic mem_valid,
  output logic board_reset
);

  // register map, byte address four times the index:
  //   command word at index 0x000, the only writable one
  //   information words from 0x7e4 up to 0x8fc
  //   status and capacity words at 0x010 and 0x011
  // any other place, or an address with low bits set,
  // answers with an error and changes no state

  // two bytes per sample from twelve bits upward, else one
  // fixed per build; no run-time setting changes it
  localparam logic [1:0] BYTES_PER_SAMPLE = (SAMPLE_BITS >= 12) ? 2'h2 : 2'h1; // [R6]

  // one write and one read in flight at most; a master
  // that pipelines requests just sees ready held low.
  // this keeps the slave small at the cost of throughput
  // on back-to-back accesses, which software never needs

  // registered state and its next value
  bir_pkg::bir_state_t st_r;
  bir_pkg::bir_state_t st_nxt;

  // assembled read-only words
  logic [31:0] date_word;
  logic [31:0] options_word;
  logic [31:0] status_word;
  logic [31:0] capacity_word;

  // byte address to register select; used for both read and write
  // one shared decode keeps reads and writes in agreement
  function automatic bir_pkg::bir_sel_t bir_decode(input logic [15:0] addr);
    bir_pkg::bir_sel_t sel;
    sel = bir_pkg::BIR_SEL_NONE;
    // unaligned or beyond the index range maps nowhere
    // upper address bits beyond the map alias nothing
    if (addr[1:0] == 2'h0 && addr[15:14] == 2'h0)
    begin
      case (addr[13:2])
        `BIR_IDX_COMMAND: sel = bir_pkg::BIR_SEL_COMMAND;
        `BIR_IDX_DATE: sel = bir_pkg::BIR_SEL_DATE;
        `BIR_IDX_SERIAL: sel = bir_pkg::BIR_SEL_SERIAL;
        `BIR_IDX_RATE: sel = bir_pkg::BIR_SEL_RATE;
        `BIR_IDX_MEMSIZE: sel = bir_pkg::BIR_SEL_MEMSIZE;
        `BIR_IDX_OPTIONS: sel = bir_pkg::BIR_SEL_OPTIONS;
        `BIR_IDX_IRQ: sel = bir_pkg::BIR_SEL_IRQ;
        `BIR_IDX_STATUS: sel = bir_pkg::BIR_SEL_STATUS;
        `BIR_IDX_CAPACITY: sel = bir_pkg::BIR_SEL_CAPACITY;
        default: sel = bir_pkg::BIR_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : bir_decode

  // straps are sampled when the read address is taken;
  // they must not change while a read is in flight
  // date word: year high, byte one left zero, month low
  always_comb
  begin
    date_word = 32'h0000_0000;
    date_word[`BIR_DATE_YEAR_LSB +: 16] = prod_year; // [R1]
    date_word[`BIR_DATE_MONTH_LSB +: 8] = prod_month; // [R2]
  end

  // options word from the fitted-option straps
  // each strap maps onto one fixed bit, the amp strap only on generators, the hub strap also onto the sync bit; unused bits read zero
  always_comb
  begin
    options_word = 32'h0000_0000;
    options_word[`BIR_OPT_MULTI_BIT] = opt_multi_record; // [R7]
    options_word[`BIR_OPT_DIGITAL_BIT] = opt_digital_inputs; // [R7]
    options_word[`BIR_OPT_GATE_BIT] = opt_gated_sampling; // [R7]
    // hub carrier always reports synchronization too
    options_word[`BIR_OPT_SYNC_BIT] = opt_synchronization | opt_sync_hub_module; // [R8] [R9]
    options_word[`BIR_OPT_TIME_BIT] = opt_time_tagging; // [R8]
    options_word[`BIR_OPT_HUB_BIT] = opt_sync_hub_module; // [R9]
    options_word[`BIR_OPT_XIO_BIT] = opt_extra_io; // [R8]
    // amplifier calibration set is meaningless on acquisition boards
    options_word[`BIR_OPT_AMP_BIT] = IS_GENERATOR & opt_amp_calibration; // [R10]
  end

  // status and capacity words are additions of this bank;
  // they read back live state and never accept writes
  // status word: mode flags, memory validity, sample size
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[0] = (st_r.mode == bir_pkg::BIR_MODE_LOW_POWER);
    status_word[1] = (st_r.mode == bir_pkg::BIR_MODE_RUN);
    status_word[2] = st_r.mem_valid;
    status_word[5:4] = BYTES_PER_SAMPLE; // [R6]
  end

  // capacity in samples; halved when each sample takes two bytes
  // an odd byte count loses its last byte to the halving
  always_comb
  begin
    if (BYTES_PER_SAMPLE == 2'h2)
    begin
      capacity_word = {1'b0, installed_memory_bytes[31:1]}; // [R6]
    end
    else
    begin
      capacity_word = installed_memory_bytes; // [R6]
    end
  end

  // a single next-state process: every field starts from its
  // held value, so branches only name what changes
  // next-state logic for bus slave and board control
  always_comb
  begin
    // locals first
    bir_pkg::bir_sel_t wsel;
    bir_pkg::bir_sel_t rsel;
    logic [31:0] merged;
    logic do_write;
    int i;
    wsel = bir_pkg::BIR_SEL_NONE;
    rsel = bir_pkg::BIR_SEL_NONE;
    merged = 32'h0000_0000;
    do_write = 1'b0;
    i = 0;
    st_nxt = st_r;
    // reset pulse lasts a single cycle
    st_nxt.board_reset = 1'b0;

    // each half is held here until its partner arrives
    // write address capture
    if (st_r.awready && s_axi_awvalid)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    // write data capture, independent of address order
    if (st_r.wready && s_axi_wvalid)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end

    // bready may come long after bvalid; nothing moves meanwhile
    // response retires when the master takes it
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // both halves present and no response pending: perform the write
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid)
    begin
      do_write = 1'b1;
      wsel = bir_decode(st_r.aw_addr);
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `BIR_RESP_OKAY;
      // byte strobes select which lanes change
      // lanes left out keep the old command bytes
      merged = st_r.command;
      for (i = 0; i < 4; i++)
      begin
        if (st_r.w_strb[i])
        begin
          merged[i*8 +: 8] = st_r.w_data[i*8 +: 8];
        end
      end
      if (wsel == bir_pkg::BIR_SEL_NONE)
      begin
        // unmapped address answers with an error
        st_nxt.bresp = `BIR_RESP_SLVERR;
      end
    end

    // command register: the only writable word
    // the code is decoded after the strobe merge, so a
    // partial write may form a command by accident
    if (do_write && wsel == bir_pkg::BIR_SEL_COMMAND)
    begin
      st_nxt.command = merged;
      case (merged)
        `BIR_CMD_FULL_RESET:
        begin
          // every setting back to default, powerdown left
          st_nxt.command = `BIR_COMMAND_RESET; // [R14]
          st_nxt.mode = bir_pkg::BIR_MODE_IDLE; // [R13] [R14]
          st_nxt.mem_valid = 1'b0; // [R15]
          st_nxt.board_reset = 1'b1; // [R14]
        end
        `BIR_CMD_LOW_POWER:
        begin
          // powering down also stops any run
          st_nxt.mode = bir_pkg::BIR_MODE_LOW_POWER; // [R12]
          st_nxt.mem_valid = 1'b0; // [R15]
        end
        `BIR_CMD_RUN_STANDARD:
        begin
          // a start also wakes the board
          st_nxt.mode = bir_pkg::BIR_MODE_RUN; // [R13] [R16]
        end
        default:
        begin
          // other codes are stored but steer nothing here
          st_nxt.mode = st_r.mode;
        end
      endcase
    end
    // writes to information registers change nothing [R17]

    // a finished acquisition validates memory, but only if the
    // board stays running: a same-cycle powerdown or reset
    // clears it, since that memory may not be read out
    if (acq_done && st_r.mode == bir_pkg::BIR_MODE_RUN && st_nxt.mode == bir_pkg::BIR_MODE_RUN)
    begin
      st_nxt.mem_valid = 1'b1; // [R15]
    end

    // mode flags kept in their own flops so the pins are clean
    st_nxt.low_power = (st_nxt.mode == bir_pkg::BIR_MODE_LOW_POWER); // [R12]
    st_nxt.run_active = (st_nxt.mode == bir_pkg::BIR_MODE_RUN); // [R13] [R16]

    // taken from the next state so ready returns on the
    // very edge at which the response is accepted
    // ready for a new address or data only when that half is empty
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    // read data retires on master acceptance
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // read data is captured at acceptance and then held
    // unchanged until the master takes it
    // read address taken: answer next cycle
    if (st_r.arready && s_axi_arvalid)
    begin
      rsel = bir_decode(s_axi_araddr);
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `BIR_RESP_OKAY;
      case (rsel)
        bir_pkg::BIR_SEL_COMMAND: st_nxt.rdata = st_r.command;
        bir_pkg::BIR_SEL_DATE: st_nxt.rdata = date_word; // [R1] [R2]
        bir_pkg::BIR_SEL_SERIAL: st_nxt.rdata = board_serial; // [R3]
        bir_pkg::BIR_SEL_RATE: st_nxt.rdata = max_sample_rate; // [R4]
        bir_pkg::BIR_SEL_MEMSIZE: st_nxt.rdata = installed_memory_bytes; // [R5]
        bir_pkg::BIR_SEL_OPTIONS: st_nxt.rdata = options_word; // [R7] [R8]
        bir_pkg::BIR_SEL_IRQ: st_nxt.rdata = {24'h00_0000, interrupt_line_used}; // [R11]
        bir_pkg::BIR_SEL_STATUS: st_nxt.rdata = status_word;
        bir_pkg::BIR_SEL_CAPACITY: st_nxt.rdata = capacity_word;
        default:
        begin
          // unmapped read: zero data, error answer
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = `BIR_RESP_SLVERR;
        end
      endcase
    end
  end

  // srst acts even with the enable low, so a frozen board
  // can still be forced back to a known state
  // state register; enable low freezes everything
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r.awready <= 1'b1;
      st_r.aw_held <= 1'b0;
      st_r.aw_addr <= 16'h0000;
      st_r.wready <= 1'b1;
      st_r.w_held <= 1'b0;
      st_r.w_data <= 32'h0000_0000;
      st_r.w_strb <= 4'h0;
      st_r.bvalid <= 1'b0;
      st_r.bresp <= `BIR_RESP_OKAY;
      st_r.arready <= 1'b1;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.rresp <= `BIR_RESP_OKAY;
      st_r.command <= `BIR_COMMAND_RESET;
      st_r.mode <= bir_pkg::BIR_MODE_IDLE;
      st_r.low_power <= 1'b0;
      st_r.run_active <= 1'b0;
      // power-on memory holds nothing worth reading
      st_r.mem_valid <= 1'b0; // [R15]
      st_r.board_reset <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // bus outputs straight from state flops
  // no output passes through logic after its flop
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // board control outputs straight from state flops
  // board_reset is a single-cycle pulse; a slow consumer must
  // stretch it on its own side
  assign low_power = st_r.low_power; // [R12]
  assign run_active = st_r.run_active; // [R13] [R16]
  // readout and replay gated by this flag
  assign mem_valid = st_r.mem_valid; // [R15]
  assign board_reset = st_r.board_reset;

endmodule : bir_board_regs

// >>> logic/bir_defs.svh
`ifndef BIR_DEFS_SVH
`define BIR_DEFS_SVH
// Behaviour
// [R1] date word: year in upper sixteen bits
// [R2] month in low byte, byte one unused
// [R3] read-only serial number unique per board
// [R4] max sample rate in hertz, unreduced
// [R5] installed memory size in bytes, read-only
// [R6] two bytes per sample from twelve bits
// [R7] option bits 1, 2, 32
// [R8] option bits 512, 1024, 8192
// [R9] hub module sets 2048 and sync bit
// [R10] bit 16384 only on waveform generators
// [R11] read-only register reports interrupt line used
// [R12] code 30 enters reduced-power mode
// [R13] reset or start command ends powerdown
// [R14] code 0 resets all settings to default
// [R15] memory invalid after powerdown or reset
// [R16] code 101 starts standard mode, ends powerdown
// [R17] writes to information registers are ignored

// register indexes; byte address is four times the index
`define BIR_IDX_COMMAND 12'h000
`define BIR_IDX_DATE 12'h7e4
`define BIR_IDX_SERIAL 12'h7ee
`define BIR_IDX_RATE 12'h834
`define BIR_IDX_MEMSIZE 12'h83e
`define BIR_IDX_OPTIONS 12'h848
`define BIR_IDX_IRQ 12'h8fc
`define BIR_IDX_STATUS 12'h010
`define BIR_IDX_CAPACITY 12'h011

// date word field positions
`define BIR_DATE_YEAR_LSB 16
`define BIR_DATE_MONTH_LSB 0

// option bit positions
`define BIR_OPT_MULTI_BIT 0
`define BIR_OPT_DIGITAL_BIT 1
`define BIR_OPT_GATE_BIT 5
`define BIR_OPT_SYNC_BIT 9
`define BIR_OPT_TIME_BIT 10
`define BIR_OPT_HUB_BIT 11
`define BIR_OPT_XIO_BIT 13
`define BIR_OPT_AMP_BIT 14

// command codes and reset value
`define BIR_CMD_FULL_RESET 32'h0000_0000
`define BIR_CMD_LOW_POWER 32'h0000_001e
`define BIR_CMD_RUN_STANDARD 32'h0000_0065
`define BIR_COMMAND_RESET 32'h0000_0000

// axi responses
`define BIR_RESP_OKAY 2'h0
`define BIR_RESP_SLVERR 2'h2
`endif

// >>> logic/bir_pkg.sv
package bir_pkg;
  // board power and run mode
  typedef enum logic [1:0] {BIR_MODE_IDLE, BIR_MODE_LOW_POWER, BIR_MODE_RUN} bir_mode_t;

  // register select from address decode
  typedef enum logic [3:0] {
    BIR_SEL_NONE, BIR_SEL_COMMAND, BIR_SEL_DATE, BIR_SEL_SERIAL, BIR_SEL_RATE,
    BIR_SEL_MEMSIZE, BIR_SEL_OPTIONS, BIR_SEL_IRQ, BIR_SEL_STATUS, BIR_SEL_CAPACITY
  } bir_sel_t;

  // whole state of the register bank
  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [15:0] aw_addr;
    logic wready;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] command;
    bir_mode_t mode;
    logic mem_valid;
    logic board_reset;
    logic low_power;
    logic run_active;
  } bir_state_t;
endpackage : bir_pkg
